/* verilog/efmb_pkg.sv */
// Constants for the event flag and interrupt mask bank.
// Assumes a single 20 MHz clock and a byte-wide serial register port in front of it.
// Contract
// - Flag register 0x4 bit2 input limit, bit1 path regulation, bit0 input voltage regulation.
// - Flag register 0x5 bit7 thermal regulation, bit6 charge timer expiry; clear on read.
// - Flag register 0x5 bits 5 and 4 latch wake timer one and two.
// - Flag register 0x5 bit3 latches conversion done, only in one-shot mode.
// - Flag register 0x5 bits 2..0 latch comparator one, two, three alarms.
// - Flag register 0x6 bit7 charge status change, bit6 sequence good change.
// - Flag register 0x6 bits 5..2 latch step-down, buck-boost, regulator one, two not good.
// - Flag register 0x6 bit1 input good change, bit0 input overvoltage; clear on read.
// - Flag register 0x7 bits 7..4 latch general pin one to four events.
// - Flag register 0x7 bits 3..0 latch rail short, depletion, overcurrent, thermal shutdown.
// - Flag registers 0x4..0x7 reset to zero and ignore writes.
// - Mask bits are read-write; one suppresses the interrupt, zero enables it.
// - Mask register 0x8 resets to 0x84; bits 5..3 reserved, read zero.
// - Mask register 0x8 bit1 gates flag bit1, bit0 gates flag bit0.
// - Mask register 0x9 resets to 0x07; comparator masks set, others clear.
// - Conversion-done mask gates only the one-shot conversion interrupt.
// - Flag register 0x4 bits 7 and 6 latch open sensor and temperature change.
package efmb_pkg;

    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [7:0] OFF_EVENT_FLAGS_REGULATION = 8'h04;
    localparam logic [7:0] OFF_EVENT_FLAGS_TIMERS_ADC = 8'h05;
    localparam logic [7:0] OFF_EVENT_FLAGS_RAILS_INPUT = 8'h06;
    localparam logic [7:0] OFF_EVENT_FLAGS_PINS_FAULTS = 8'h07;
    localparam logic [7:0] OFF_INTERRUPT_MASKS_REGULATION = 8'h08;
    localparam logic [7:0] OFF_INTERRUPT_MASKS_TIMERS_ADC = 8'h09;

    // ****************************************************************
    // Values after reset and writable fields.
    // ****************************************************************
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_MASKS_REGULATION = 8'h84;
    localparam logic [7:0] RST_MASKS_TIMERS_ADC = 8'h07;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] USED_BITS_REGULATION = 8'hc7;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ****************************************************************
    // Bit positions in the regulation flag and mask registers.
    // ****************************************************************
    localparam int OPEN_SENSOR_EVENT_FLAG_BIT = 7;
    localparam int TEMP_STATUS_CHANGE_FLAG_BIT = 6;
    localparam int INPUT_LIMIT_EVENT_FLAG_BIT = 2;
    localparam int SYS_PATHREG_EVENT_FLAG_BIT = 1;
    localparam int INPUTV_REG_EVENT_FLAG_BIT = 0;

    // ****************************************************************
    // Bit positions in the timer and converter flag and mask registers.
    // ****************************************************************
    localparam int THERMAL_REG_EVENT_FLAG_BIT = 7;
    localparam int CHARGE_TIMER_EXPIRED_FLAG_BIT = 6;
    localparam int WAKE_TIMER_ONE_FLAG_BIT = 5;
    localparam int WAKE_TIMER_TWO_FLAG_BIT = 4;
    localparam int CONVERSION_DONE_FLAG_BIT = 3;
    localparam int COMPARATOR_ONE_ALARM_FLAG_BIT = 2;
    localparam int COMPARATOR_TWO_ALARM_FLAG_BIT = 1;
    localparam int COMPARATOR_THREE_ALARM_FLAG_BIT = 0;

    // ****************************************************************
    // Sizes of the event bundle.
    // ****************************************************************
    localparam int FLAG_REGS = 4;
    localparam int FLAG_WIDTH = 8;
    localparam int EVENT_WIDTH = FLAG_REGS * FLAG_WIDTH;

endpackage

/* verilog/efmb_event_if.sv */
// Interface carrying the synchronised event levels to the flag bank.
// Assumes producer and consumer share one clock.
`timescale 1ns/1ps
interface efmb_event_if #(
    parameter int WIDTH = 32
);
    logic [WIDTH-1:0] events;

    modport producer (output events);
    modport consumer (input events);
endinterface

/* verilog/efmb_event_sync.sv */
// Two-stage synchroniser for the raw event levels from the analog blocks.
// Assumes the event sources are asynchronous to i_clock.
`timescale 1ns/1ps
module efmb_event_sync
    import efmb_pkg::*;
#(
    parameter int WIDTH = EVENT_WIDTH
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Raw event levels.
    input wire logic [WIDTH-1:0] i_events,
    // Synchronised event levels.
    efmb_event_if.producer sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage_one;
        logic [WIDTH-1:0] stage_two;
    } efmb_sync_s;

    efmb_sync_s state_ff;
    efmb_sync_s nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.stage_one = i_events;
        nxt_state.stage_two = state_ff.stage_one;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out.events = state_ff.stage_two;

endmodule

/* verilog/efmb_flag_bank.sv */
// Clear-on-read event flags, interrupt masks and interrupt request.
// Assumes a serial register port that presents one byte access per strobe, on i_clock.
`timescale 1ns/1ps
module efmb_flag_bank
    import efmb_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Register port.
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_reset_cmd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Raw event levels from the charger, converter, rails, pins and protection.
    input wire logic [7:0] i_regulation_events,
    input wire logic [7:0] i_timer_adc_events,
    input wire logic [7:0] i_rail_input_events,
    input wire logic [7:0] i_pin_fault_events,
    input wire logic i_adc_oneshot,
    // Interrupt request to the host.
    output logic o_irq
);

    // ****************************************************************
    // Synchronisation of the event levels.
    // ****************************************************************
    efmb_event_if #(.WIDTH(EVENT_WIDTH)) sync_bus ();

    efmb_event_sync #(
        .WIDTH(EVENT_WIDTH)
    ) u_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_events({i_pin_fault_events, i_rail_input_events,
                   i_timer_adc_events, i_regulation_events}),
        .sync_out(sync_bus.producer)
    );

    // ****************************************************************
    // Block state.
    // ****************************************************************
    typedef struct packed {
        logic [7:0] flags_regulation;
        logic [7:0] flags_timers_adc;
        logic [7:0] flags_rails_input;
        logic [7:0] flags_pins_faults;
        logic [7:0] masks_regulation;
        logic [7:0] masks_timers_adc;
        logic [7:0] rdata;
        logic rvalid;
        logic irq;
        logic oneshot_meta;
        logic oneshot_sync;
    } efmb_bank_s;

    localparam efmb_bank_s BANK_RESET = '{
        flags_regulation: RST_FLAGS,
        flags_timers_adc: RST_FLAGS,
        flags_rails_input: RST_FLAGS,
        flags_pins_faults: RST_FLAGS,
        masks_regulation: RST_MASKS_REGULATION,
        masks_timers_adc: RST_MASKS_TIMERS_ADC,
        rdata: RST_READ_DATA,
        rvalid: 1'b0,
        irq: 1'b0,
        oneshot_meta: 1'b0,
        oneshot_sync: 1'b0
    };

    efmb_bank_s state_ff;
    efmb_bank_s nxt_state;

    // ****************************************************************
    // Event decode.
    // ****************************************************************
    logic [7:0] set_regulation;
    logic [7:0] set_timers_adc;
    logic [7:0] set_rails_input;
    logic [7:0] set_pins_faults;
    logic [7:0] masked_timers_adc;

    always_comb begin
        // Bits 5..3 of the regulation group carry no event.
        set_regulation = sync_bus.events[7:0] & USED_BITS_REGULATION;
        set_timers_adc = sync_bus.events[15:8];
        // Conversion done only counts in one-shot mode.
        set_timers_adc[CONVERSION_DONE_FLAG_BIT] =
            sync_bus.events[8 + CONVERSION_DONE_FLAG_BIT] & state_ff.oneshot_sync;
        set_rails_input = sync_bus.events[23:16];
        set_pins_faults = sync_bus.events[31:24];
    end

    // ****************************************************************
    // Register access and flag update.
    // ****************************************************************
    logic rd_regulation;
    logic rd_timers_adc;
    logic rd_rails_input;
    logic rd_pins_faults;

    assign rd_regulation = i_reg_rd && (i_reg_addr == OFF_EVENT_FLAGS_REGULATION);
    assign rd_timers_adc = i_reg_rd && (i_reg_addr == OFF_EVENT_FLAGS_TIMERS_ADC);
    assign rd_rails_input = i_reg_rd && (i_reg_addr == OFF_EVENT_FLAGS_RAILS_INPUT);
    assign rd_pins_faults = i_reg_rd && (i_reg_addr == OFF_EVENT_FLAGS_PINS_FAULTS);

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = i_reg_rd;
        // The mode level is asynchronous too, so it passes two flip-flops.
        nxt_state.oneshot_meta = i_adc_oneshot;
        nxt_state.oneshot_sync = state_ff.oneshot_meta;

        // Read data is the value before clearing; bits returned are the bits cleared.
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                OFF_EVENT_FLAGS_REGULATION: begin
                    nxt_state.rdata = state_ff.flags_regulation;
                end
                OFF_EVENT_FLAGS_TIMERS_ADC: begin
                    nxt_state.rdata = state_ff.flags_timers_adc;
                end
                OFF_EVENT_FLAGS_RAILS_INPUT: begin
                    nxt_state.rdata = state_ff.flags_rails_input;
                end
                OFF_EVENT_FLAGS_PINS_FAULTS: begin
                    nxt_state.rdata = state_ff.flags_pins_faults;
                end
                OFF_INTERRUPT_MASKS_REGULATION: begin
                    nxt_state.rdata = state_ff.masks_regulation;
                end
                OFF_INTERRUPT_MASKS_TIMERS_ADC: begin
                    nxt_state.rdata = state_ff.masks_timers_adc;
                end
                default: begin
                    nxt_state.rdata = UNMAPPED_READ_VALUE;
                end
            endcase
        end

        // Clear what was read, then set from events so a new event wins.
        nxt_state.flags_regulation = (state_ff.flags_regulation
            & ~(rd_regulation ? state_ff.flags_regulation : 8'h00))
            | set_regulation;
        nxt_state.flags_timers_adc = (state_ff.flags_timers_adc
            & ~(rd_timers_adc ? state_ff.flags_timers_adc : 8'h00))
            | set_timers_adc;
        nxt_state.flags_rails_input = (state_ff.flags_rails_input
            & ~(rd_rails_input ? state_ff.flags_rails_input : 8'h00))
            | set_rails_input;
        nxt_state.flags_pins_faults = (state_ff.flags_pins_faults
            & ~(rd_pins_faults ? state_ff.flags_pins_faults : 8'h00))
            | set_pins_faults;

        // Flags take no writes; masks are read-write with reserved bits held at zero.
        if (i_reg_wr && (i_reg_addr == OFF_INTERRUPT_MASKS_REGULATION)) begin
            nxt_state.masks_regulation = i_reg_wdata & USED_BITS_REGULATION;
        end
        if (i_reg_wr && (i_reg_addr == OFF_INTERRUPT_MASKS_TIMERS_ADC)) begin
            nxt_state.masks_timers_adc = i_reg_wdata;
        end

        // Register-reset command restores the masks and leaves the flags alone.
        if (i_reg_reset_cmd) begin
            nxt_state.masks_regulation = RST_MASKS_REGULATION;
            nxt_state.masks_timers_adc = RST_MASKS_TIMERS_ADC;
        end

        // Each mask bit gates the flag bit of the same position.
        masked_timers_adc = nxt_state.flags_timers_adc & ~nxt_state.masks_timers_adc;
        // The conversion-done request stands only in one-shot mode.
        masked_timers_adc[CONVERSION_DONE_FLAG_BIT] =
            masked_timers_adc[CONVERSION_DONE_FLAG_BIT] & state_ff.oneshot_sync;
        nxt_state.irq =
            (|(nxt_state.flags_regulation & ~nxt_state.masks_regulation))
            || (|masked_timers_adc)
            || (|nxt_state.flags_rails_input)
            || (|nxt_state.flags_pins_faults);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_ff <= BANK_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_reg_rdata = state_ff.rdata;
    assign o_reg_rvalid = state_ff.rvalid;
    assign o_irq = state_ff.irq;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_read_timers_quiet;
        rd_timers_adc && (set_timers_adc == 8'h00);
    endsequence

    sequence s_cleared_after;
        (state_ff.flags_timers_adc == 8'h00) && o_reg_rvalid;
    endsequence

    a_read_clears_timers: assert property (
        s_read_timers_quiet |=> s_cleared_after)
        else $error("timer flags not cleared by a quiet read");

    a_read_returns_flags: assert property (
        rd_pins_faults |=> (o_reg_rdata == $past(state_ff.flags_pins_faults)))
        else $error("read data does not match flags before the read");

    a_event_survives_read: assert property (
        rd_rails_input && set_rails_input[0] |=> state_ff.flags_rails_input[0])
        else $error("event during read was lost");

    sequence s_pin_event_arrives;
        $rose(i_pin_fault_events[0]) ##2 1'b1;
    endsequence

    a_sync_sets_flag: assert property (
        s_pin_event_arrives |=> state_ff.flags_pins_faults[0])
        else $error("thermal shutdown event did not latch in three cycles");

    a_flag_holds: assert property (
        state_ff.flags_rails_input[7] && !rd_rails_input |=>
            state_ff.flags_rails_input[7])
        else $error("flag dropped without a read");

    a_oneshot_gate: assert property (
        !state_ff.oneshot_sync && !state_ff.flags_timers_adc[CONVERSION_DONE_FLAG_BIT] |=>
            !state_ff.flags_timers_adc[CONVERSION_DONE_FLAG_BIT])
        else $error("conversion done latched outside one-shot mode");

    a_mask_reserved_zero: assert property (
        (state_ff.masks_regulation & ~USED_BITS_REGULATION) == 8'h00)
        else $error("reserved mask bits are not zero");

    a_reset_cmd_masks: assert property (
        i_reg_reset_cmd |=> (state_ff.masks_regulation == RST_MASKS_REGULATION)
            && (state_ff.masks_timers_adc == RST_MASKS_TIMERS_ADC))
        else $error("register reset did not restore the masks");

    a_mask_write_taken: assert property (
        i_reg_wr && !i_reg_reset_cmd && (i_reg_addr == OFF_INTERRUPT_MASKS_TIMERS_ADC)
            |=> state_ff.masks_timers_adc == $past(i_reg_wdata))
        else $error("mask write not stored");

    a_irq_follows_flags: assert property (
        o_irq == ((|(state_ff.flags_regulation & ~state_ff.masks_regulation))
            || (|(state_ff.flags_timers_adc & ~state_ff.masks_timers_adc
                & ~($past(state_ff.oneshot_sync) ? 8'h00 : 8'h08)))
            || (|state_ff.flags_rails_input) || (|state_ff.flags_pins_faults)))
        else $error("interrupt request disagrees with flags and masks");

    a_flag_write_ignored: assert property (
        i_reg_wr && (i_reg_addr == OFF_EVENT_FLAGS_PINS_FAULTS) && !rd_pins_faults
            && (set_pins_faults == 8'h00)
            |=> state_ff.flags_pins_faults == $past(state_ff.flags_pins_faults))
        else $error("write changed a flag register");

    a_unmapped_read_zero: assert property (
        i_reg_rd && (i_reg_addr > OFF_INTERRUPT_MASKS_TIMERS_ADC)
            |=> o_reg_rvalid && (o_reg_rdata == UNMAPPED_READ_VALUE))
        else $error("unmapped read not zero");

    a_rvalid_pulse: assert property (
        o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid does not follow the strobe");

    a_rdata_holds: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");

    // ****************************************************************
    // Per-register clear-on-read checks.
    // ****************************************************************
    logic [FLAG_REGS-1:0][7:0] flags_view;
    logic [FLAG_REGS-1:0][7:0] set_view;
    logic [FLAG_REGS-1:0] rd_view;

    assign flags_view = {state_ff.flags_pins_faults, state_ff.flags_rails_input,
        state_ff.flags_timers_adc, state_ff.flags_regulation};
    assign set_view = {set_pins_faults, set_rails_input, set_timers_adc, set_regulation};
    assign rd_view = {rd_pins_faults, rd_rails_input, rd_timers_adc, rd_regulation};

    generate
        for (genvar g = 0; g < FLAG_REGS; g++) begin : g_flag_checks
            a_group_read_data: assert property (
                rd_view[g] |=> o_reg_rvalid && (o_reg_rdata == $past(flags_view[g])))
                else $error("flag read returned the wrong byte");

            a_group_quiet_clear: assert property (
                rd_view[g] && (set_view[g] == 8'h00) |=> flags_view[g] == 8'h00)
                else $error("quiet read left a flag set");

            a_group_flags_stick: assert property (
                !rd_view[g] |=> (flags_view[g] & $past(flags_view[g])) == $past(flags_view[g]))
                else $error("flag dropped without a read");
        end
    endgenerate

    // ****************************************************************
    // Reset, mask and request checks.
    // ****************************************************************
    a_reset_values: assert property (
        $rose(i_rst_b) |-> (flags_view == '0) && !o_irq
            && (state_ff.masks_regulation == RST_MASKS_REGULATION)
            && (state_ff.masks_timers_adc == RST_MASKS_TIMERS_ADC))
        else $error("state after reset is wrong");

    a_mask_write_regulation: assert property (
        i_reg_wr && !i_reg_reset_cmd && (i_reg_addr == OFF_INTERRUPT_MASKS_REGULATION)
            |=> state_ff.masks_regulation == ($past(i_reg_wdata) & USED_BITS_REGULATION))
        else $error("regulation mask write not stored");

    a_irq_rails_unmasked: assert property (
        (|state_ff.flags_rails_input) || (|state_ff.flags_pins_faults) |-> o_irq)
        else $error("unmasked flag raised no request");

    a_irq_needs_flag: assert property (
        o_irq |-> (flags_view != '0))
        else $error("request without any flag");

    // Only the conversion-done flag is about to be set.
    logic conv_only_next;

    assign conv_only_next = (nxt_state.flags_timers_adc == 8'h08)
        && (nxt_state.flags_regulation == 8'h00) && (nxt_state.flags_rails_input == 8'h00)
        && (nxt_state.flags_pins_faults == 8'h00);

    a_conv_irq_gated: assert property (
        !state_ff.oneshot_sync && conv_only_next |=> !o_irq)
        else $error("conversion request outside one-shot mode");

    a_conv_mask_gates: assert property (
        nxt_state.masks_timers_adc[CONVERSION_DONE_FLAG_BIT] && conv_only_next |=> !o_irq)
        else $error("masked conversion raised a request");

endmodule

/* verification/efmb_host_model.sv */
// Host processor model that reads and writes the flag bank through its register port.
// Assumes the bank answers a read with a one-cycle valid pulse on the following edge.
`timescale 1ns/1ps
module efmb_host_model (
    // Clock.
    input wire logic i_clock,
    // Register port towards the device.
    output logic [7:0] o_reg_addr,
    output logic o_reg_rd,
    output logic o_reg_wr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_reset_cmd,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_reg_rvalid
);
    logic timed_out = 1'b0;

    initial begin
        o_reg_addr = 8'h00;
        o_reg_rd = 1'b0;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_reset_cmd = 1'b0;
    end

    // ****************************************************************
    // Bus cycles, entered just after a rising edge.
    // ****************************************************************
    // A read takes one strobe cycle and one idle cycle, so strobes never touch.
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        int n;
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(posedge i_clock);
        #1;
        o_reg_rd = 1'b0;
        n = 0;
        while (i_reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        if (i_reg_rvalid !== 1'b1) begin
            timed_out = 1'b1;
        end
        d = i_reg_rdata;
        o_reg_addr = ~a;
        @(posedge i_clock);
        #1;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(posedge i_clock);
        #1;
        o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
        @(posedge i_clock);
        #1;
    endtask

    task automatic reset_command();
        o_reg_reset_cmd = 1'b1;
        @(posedge i_clock);
        #1;
        o_reg_reset_cmd = 1'b0;
        @(posedge i_clock);
        #1;
    endtask
endmodule

/* verification/efmb_testbench.sv */
// Self-checking testbench for the event flag and interrupt mask bank.
// Assumes the host model drives the register port and the bench drives the event levels.
`timescale 1ns/1ps
module testbench;
    import efmb_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] ev [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic oneshot = 1'b0;
    wire logic [7:0] addr;
    wire logic [7:0] wdata;
    wire logic [7:0] rdata;
    wire logic rd;
    wire logic wr;
    wire logic rcmd;
    wire logic rvalid;
    wire logic irq;
    int failures = 0;
    int cmp_count = 0;

    always #25 i_clock = ~i_clock;

    efmb_host_model host (.i_clock(i_clock), .o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr),
        .o_reg_wdata(wdata), .o_reg_reset_cmd(rcmd), .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid));

    efmb_flag_bank DUT (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_addr(addr),
        .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_reset_cmd(rcmd),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_regulation_events(ev[0]),
        .i_timer_adc_events(ev[1]), .i_rail_input_events(ev[2]),
        .i_pin_fault_events(ev[3]), .i_adc_oneshot(oneshot), .o_irq(irq));

    // ****************************************************************
    // Shared helpers.
    // ****************************************************************
    task automatic complete_run();
        if (host.timed_out) begin
            failures++;
        end
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.reg_read(a, d);
        if (host.timed_out) begin
            complete_run();
        end
        check(d, exp);
    endtask

    // Pulses an event level long enough to pass the synchroniser, then lets it drain.
    task automatic pulse_event(input int r, input logic [7:0] v);
        ev[r] = v;
        cycles(3);
        ev[r] = 8'h00;
        cycles(3);
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic test_reset();
        logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 8'h07};
        for (int i = 0; i < 6; i++) begin
            rd_chk(8'h04 + 8'(i), exp[i]);
        end
        rd_chk(8'h20, 8'h00);
        check({7'h00, irq}, 8'h00);
    endtask

    // Every flag bit in turn, with the interrupt judged against the reset masks.
    task automatic test_latch_all();
        logic [7:0] bit_v;
        logic [7:0] m;
        logic [7:0] keep;
        oneshot = 1'b1;
        for (int r = 0; r < 4; r++) begin
            for (int b = 0; b < 8; b++) begin
                bit_v = 8'h01 << b;
                m = (r == 0) ? 8'h84 : (r == 1) ? 8'h07 : 8'h00;
                keep = (r == 0) ? (bit_v & 8'hc7) : bit_v;
                ev[r] = bit_v;
                cycles(3);
                check({7'h00, irq}, {7'h00, |(keep & ~m)});
                ev[r] = 8'h00;
                cycles(3);
                rd_chk(8'h04 + 8'(r), keep);
                rd_chk(8'h04 + 8'(r), 8'h00);
            end
        end
        oneshot = 1'b0;
        cycles(3);
    endtask

    task automatic test_oneshot_gate();
        host.reg_write(8'h09, 8'h00);
        ev[1] = 8'h08;
        cycles(3);
        check({7'h00, irq}, 8'h00);
        ev[1] = 8'h00;
        cycles(3);
        rd_chk(8'h05, 8'h00);
        // A latched conversion flag requests only while unmasked and in one-shot mode.
        oneshot = 1'b1;
        host.reg_write(8'h09, 8'h08);
        pulse_event(1, 8'h08);
        check({7'h00, irq}, 8'h00);
        host.reg_write(8'h09, 8'h00);
        check({7'h00, irq}, 8'h01);
        oneshot = 1'b0;
        cycles(3);
        check({7'h00, irq}, 8'h00);
        rd_chk(8'h05, 8'h08);
    endtask

    task automatic test_masks();
        host.reg_write(8'h08, 8'hff);
        rd_chk(8'h08, 8'hc7);
        host.reg_write(8'h09, 8'hff);
        rd_chk(8'h09, 8'hff);
        host.reg_write(8'h08, 8'h00);
        rd_chk(8'h08, 8'h00);
        host.reg_write(8'h05, 8'hff);
        rd_chk(8'h05, 8'h00);
        host.reset_command();
        rd_chk(8'h08, 8'h84);
        rd_chk(8'h09, 8'h07);
    endtask

    task automatic test_irq_mask();
        host.reg_write(8'h08, 8'h00);
        pulse_event(0, 8'h02);
        check({7'h00, irq}, 8'h01);
        host.reg_write(8'h08, 8'h02);
        check({7'h00, irq}, 8'h00);
        host.reg_write(8'h08, 8'h01);
        check({7'h00, irq}, 8'h01);
        rd_chk(8'h04, 8'h02);
        check({7'h00, irq}, 8'h00);
    endtask

    // A level still high during the read keeps its flag for the next read.
    task automatic test_read_race();
        ev[3] = 8'h10;
        cycles(3);
        rd_chk(8'h07, 8'h10);
        ev[3] = 8'h00;
        cycles(3);
        rd_chk(8'h07, 8'h10);
        rd_chk(8'h07, 8'h00);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (12) @(posedge i_clock);
        #1;
        i_rst_b = 1'b1;
        test_reset();
        test_latch_all();
        test_oneshot_gate();
        test_masks();
        test_irq_mask();
        test_read_race();
        complete_run();
    end
endmodule
